// *** dv/dpfc_issue_model.sv ***
`timescale 1ns/1ps
module dpfc_issue_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        busy,
  input  wire logic        go,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] op_a,
  input  wire logic [63:0] op_b,
  output logic             issue_valid,
  output logic      [31:0] issue_instr,
  output logic      [63:0] src_a_data,
  output logic      [63:0] src_b_data
);
  // Offers one instruction while idle, scrambles fields one cycle later, taken or not
  always @(posedge clock) begin
    if (!rst_n) begin
      issue_valid <= 1'b0;
      issue_instr <= 32'h0;
      src_a_data  <= 64'h0;
      src_b_data  <= 64'h0;
    end else if (issue_valid) begin
      issue_valid <= 1'b0;
      issue_instr <= ~issue_instr;
      src_a_data  <= ~src_a_data;
      src_b_data  <= ~src_b_data;
    end else if (go && !busy) begin
      issue_valid <= 1'b1;
      issue_instr <= instr;
      src_a_data  <= op_a;
      src_b_data  <= op_b;
    end
  end
endmodule : dpfc_issue_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import dpfc_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, go = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        busy, done, wb_en, wb_full, irq_data, irq_round, issue_valid;
  logic [4:0]  wb_dst, wb_src_a, wb_src_b;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] instr = 32'h0, reg_wdata = 32'h0, issue_instr, reg_rdata, rd_val;
  logic [63:0] op_a = 64'h0, op_b = 64'h0, src_a_data, src_b_data, wb_data, ra, rb;
  int          num_errors = 0, num_checks = 0, cyc = 0, n = 0, k, lat;

  dpfc_core dpfc_core_inst (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .src_a_data(src_a_data), .src_b_data(src_b_data),
    .busy(busy), .done(done), .wb_en(wb_en), .wb_full(wb_full), .wb_dst(wb_dst),
    .wb_src_a(wb_src_a), .wb_src_b(wb_src_b), .wb_data(wb_data), .irq_data(irq_data),
    .irq_round(irq_round), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dpfc_issue_model dpfc_issue_model_inst (.clock(clock), .rst_n(rst_n), .busy(busy),
    .go(go), .instr(instr), .op_a(op_a), .op_b(op_b), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .src_a_data(src_a_data), .src_b_data(src_b_data));

  task automatic close_out;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // eo = {wb_en, irq_data, irq_round}; em masks the status bits compared
  task automatic run(input logic [10:0] xo, input logic [63:0] a, input logic [63:0] b,
                     input logic [6:0] ctl, input logic [63:0] ed, input logic [2:0] eo,
                     input logic [6:0] es, input logic [6:0] em);
    wr(REG_CTRL, {25'h0, ctl});
    wr(REG_STATUS, 32'h0);
    n++;
    instr <= {PRIMARY_OP, n[4:0], ~n[4:0], n[6:2], xo};
    op_a  <= a;
    op_b  <= b;
    go    <= 1'b1;
    @(posedge clock);
    go    <= 1'b0;
    lat = 0;
    do begin
      @(posedge clock);
      #1 lat++;
      if (lat == 1) chk("busy", busy, 1'b1);
    end while (done !== 1'b1 && lat < 80);
    chk("done", done, 1'b1);
    chk("busy_done", busy, 1'b0);
    chk("wb_ctl", {wb_en, irq_data, irq_round}, eo);
    chk("wb_idx", {wb_dst, wb_src_a, wb_src_b}, {n[4:0], ~n[4:0], n[6:2]});
    if (eo[2]) begin
      chk("wb_data", wb_data, ed);
      chk("wb_full", wb_full, xo inside {XO_CUIDZ, XO_DIV, XO_MUL});
    end
    rd(REG_STATUS);
    chk("status", rd_val[6:0] & em, es & em);
  endtask : run

  function automatic logic [63:0] rnd();
    return {1'($urandom), 11'($urandom_range(32'h43F, 32'h3C0)), 20'($urandom), $urandom};
  endfunction : rnd

  initial begin
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    void'($urandom(83));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_STATUS);
    chk("status_rst", rd_val, 32'h0);
    rd(REG_CTRL);
    chk("ctrl_rst", rd_val, 32'h0);
    wr(REG_CTRL, 32'hFFFFFFFF);
    rd(REG_CTRL);
    chk("ctrl_rw", rd_val, 32'h7F);
    @(posedge clock);
    #1 chk("rdata_idle", reg_rdata, 64'h0);
    wr(8'h08, 32'hFF);
    rd(8'h08);
    chk("unmapped", rd_val, 32'h0);
    @(posedge clock);
    instr <= {PRIMARY_OP, 15'h0000, 11'h7FF};
    go    <= 1'b1;
    @(posedge clock);
    go    <= 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1 chk("refused", {busy, done}, 2'b00);
    end
    run(XO_MUL, 64'h4000000000000000, 64'h4008000000000000, 7'h00, 64'h4018000000000000,
        3'b100, 7'h00, 7'h1F);
    run(XO_MUL, 64'hC000000000000000, 64'h0, 7'h00, 64'h8000000000000000, 3'b100, 7'h00, 7'h1F);
    run(XO_MUL, 64'h7FF0000000000000, 64'hC000000000000000, 7'h00, 64'hFFEFFFFFFFFFFFFF, 3'b100, 7'h01, 7'h7F);
    run(XO_MUL, 64'h7FF0000000000000, 64'hC000000000000000, 7'h01, 64'h0, 3'b010, 7'h01, 7'h7F);
    run(XO_MUL, 64'h7E70000000000000, 64'h7E70000000000000, 7'h00, 64'h7FEFFFFFFFFFFFFF, 3'b100, 7'h14, 7'h7F);
    run(XO_MUL, 64'h7E70000000000000, 64'h7E70000000000000, 7'h04, 64'h0, 3'b010, 7'h04, 7'h7F);
    run(XO_MUL, 64'h0170000000000000, 64'h0170000000000000, 7'h00, 64'h0, 3'b100, 7'h08, 7'h7F);
    run(XO_DIV, 64'h3FF0000000000000, 64'hFFF8000000000000, 7'h00, 64'h8000000000000000, 3'b100, 7'h01, 7'h7F);
    run(XO_DIV, 64'hBFF0000000000000, 64'h0, 7'h00, 64'hFFEFFFFFFFFFFFFF, 3'b100, 7'h02, 7'h7F);
    run(XO_DIV, 64'hBFF0000000000000, 64'h0, 7'h02, 64'h0, 3'b010, 7'h02, 7'h7F);
    run(XO_DIV, 64'h0, 64'h0, 7'h00, 64'h7FEFFFFFFFFFFFFF, 3'b100, 7'h01, 7'h7F);
    run(XO_DIV, 64'h7FF0000000000000, 64'h4000000000000000, 7'h01, 64'h0, 3'b010, 7'h01, 7'h7F);
    for (k = 0; k < 4; k++) begin
      run(XO_CUI, 64'h0, 64'h4004000000000000, {k[1:0], 5'h00}, (k == 2) ? 64'h3 : 64'h2, 3'b100, 7'h10, 7'h1F);
    end
    run(XO_CUIZ, 64'h0, 64'h400C000000000000, 7'h00, 64'h3, 3'b100, 7'h10, 7'h1F);
    run(XO_CUI, 64'h0, 64'h400C000000000000, 7'h10, 64'h3, 3'b101, 7'h30, 7'h7F);
    run(XO_CUF, 64'h0, 64'h3FE0000000000000, 7'h00, 64'h80000000, 3'b100, 7'h00, 7'h1F);
    run(XO_CUF, 64'h0, 64'h3FF0000000000000, 7'h00, 64'hFFFFFFFF, 3'b100, 7'h01, 7'h7F);
    run(XO_CUI, 64'h0, 64'h7FF8000000000000, 7'h00, 64'h0, 3'b100, 7'h01, 7'h7F);
    run(XO_CUI, 64'h0, 64'h7FF8000000000000, 7'h01, 64'h0, 3'b010, 7'h01, 7'h7F);
    run(XO_CUI, 64'h0, 64'h41F0000000000000, 7'h00, 64'hFFFFFFFF, 3'b100, 7'h01, 7'h7F);
    run(XO_CUIDZ, 64'h0, 64'h4270000000000800, 7'h00, 64'h10000000000, 3'b100, 7'h10, 7'h1F);
    run(XO_CUIDZ, 64'h0, 64'hBFF8000000000000, 7'h00, 64'h0, 3'b100, 7'h01, 7'h7F);
    repeat (12) begin
      ra = rnd();
      rb = rnd();
      run(XO_MUL, ra, rb, 7'h00, $realtobits($bitstoreal(ra) * $bitstoreal(rb)), 3'b100, 7'h00, 7'h00);
      chk("mul_lat", lat, 2);
      run(XO_DIV, ra, rb, 7'h00, $realtobits($bitstoreal(ra) / $bitstoreal(rb)), 3'b100, 7'h00, 7'h00);
      chk("div_lat", lat, 60);
    end
    close_out();
  end
endmodule : tb_top

// *** logic/dpfc_core.sv ***
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
// Operation
// - Double to unsigned fraction, current rounding, saturate
// - Double to unsigned 32-bit integer, saturate
// - Double to unsigned 64-bit, truncate, full write
// - Unsigned 32-bit toward-zero conversion always truncating
// - Doubleword conversion only in 64-bit builds
// - NaN source converts as zero
// - Conversion invalid clears guard; enabled blocks write
// - Inexact sets sticky; enabled raises round interrupt
// - Round interrupt still writes truncated result
// - Divide by NaN or infinity gives zero
// - Else zero/denormal divisor or NaN/infinite dividend saturates by signs; zero/denormal dividend gives zero
// - Overflow saturates, underflow gives signed zero
// - Divide invalid cases; enabled blocks write
// - Zero divisor with normal dividend flags divide-by-zero
// - Overflow/underflow flags; enabled interrupt blocks write
// - Divide inexact, or disabled overflow, sets sticky
// - Divide exceptions clear guard and sticky bits
// - Multiply by zero or denormal gives zero
// - Else multiply NaN or infinity saturates
// - Multiply invalid cases; enabled blocks write
module dpfc_core
  import dpfc_pkg::*;
#(
  parameter bit IMPL64 = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [63:0] src_a_data,
  input  wire logic [63:0] src_b_data,
  output logic             busy,
  output logic             done,
  output logic             wb_en,
  output logic             wb_full,
  output logic [4:0]       wb_dst,
  output logic [4:0]       wb_src_a,
  output logic [4:0]       wb_src_b,
  output logic [63:0]      wb_data,
  output logic             irq_data,
  output logic             irq_round,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);
  dpfc_state_t state_reg;
  dpfc_state_t state_next;
  dpfc_op_t    op_reg;
  dpfc_op_t    op_next;
  logic [63:0] src_a_reg;
  logic [63:0] src_b_reg;
  logic [4:0]  dst_reg;
  logic [4:0]  ia_reg;
  logic [4:0]  ib_reg;
  logic [6:0]  status_reg;
  logic [6:0]  status_next;
  logic [6:0]  ctrl_reg;
  logic [6:0]  ctrl_next;
  logic        busy_reg;
  logic        done_reg;
  logic        wb_en_reg;
  logic        wb_full_reg;
  logic [4:0]  wb_dst_reg;
  logic [4:0]  wb_src_a_reg;
  logic [4:0]  wb_src_b_reg;
  logic [63:0] wb_data_reg;
  logic        irq_data_reg;
  logic        irq_round_reg;
  logic [31:0] rdata_reg;

  // Instruction decode
  wire [5:0]  ins_prim = issue_instr[31:26];
  wire [10:0] ins_xo   = issue_instr[10:0];
  wire [4:0]  ins_dst  = issue_instr[25:21];
  wire [4:0]  ins_a    = issue_instr[20:16];
  wire [4:0]  ins_b    = issue_instr[15:11];
  wire        ins_pri  = ins_prim == PRIMARY_OP;
  wire        is_cuf   = ins_pri && ins_xo == XO_CUF;
  wire        is_cui   = ins_pri && ins_xo == XO_CUI;
  wire        is_cuiz  = ins_pri && ins_xo == XO_CUIZ;
  wire        is_cuidz = ins_pri && ins_xo == XO_CUIDZ && IMPL64;
  wire        is_div   = ins_pri && ins_xo == XO_DIV;
  wire        is_mul   = ins_pri && ins_xo == XO_MUL;
  wire        ins_hit  = is_cuf | is_cui | is_cuiz | is_cuidz | is_div | is_mul;
  wire        accept   = issue_valid & ~busy_reg & ins_hit;

  assign op_next = is_cuf ? OP_CUF : is_cui ? OP_CUI : is_cuiz ? OP_CUIZ :
                   is_cuidz ? OP_CUIDZ : is_div ? OP_DIV : OP_MUL;

  // Control fields
  wire       en_inv = ctrl_reg[EN_INV];
  wire       en_dbz = ctrl_reg[EN_DBZ];
  wire       en_ovf = ctrl_reg[EN_OVF];
  wire       en_unf = ctrl_reg[EN_UNF];
  wire       en_inx = ctrl_reg[EN_INX];
  wire [1:0] rm     = ctrl_reg[CT_RM +: 2];

  // Operand classification
  wire [3:0] cla   = dp_class(src_a_reg);
  wire [3:0] clb   = dp_class(src_b_reg);
  wire       sgn_r = src_a_reg[63] ^ src_b_reg[63];
  wire       bad_a = cla[CL_NAN] | cla[CL_INF] | cla[CL_DEN];
  wire       bad_b = clb[CL_NAN] | clb[CL_INF] | clb[CL_DEN];
  wire       is_dv = op_reg == OP_DIV;
  wire       is_ml = op_reg == OP_MUL;
  wire       is_cv = ~is_dv & ~is_ml;
  wire [52:0] man_a = {1'b1, src_a_reg[51:0]};
  wire [52:0] man_b = {1'b1, src_b_reg[51:0]};
  wire signed [13:0] exp_a = $signed({3'b000, src_a_reg[62:52]});
  wire signed [13:0] exp_b = $signed({3'b000, src_b_reg[62:52]});

  // Divide special results
  wire d_zero  = clb[CL_NAN] | clb[CL_INF];
  wire d_sat   = ~d_zero & (clb[CL_ZERO] | clb[CL_DEN] | cla[CL_NAN] | cla[CL_INF]);
  wire d_flush = ~d_zero & ~d_sat & (cla[CL_ZERO] | cla[CL_DEN]);
  wire d_inv   = bad_a | bad_b | (cla[CL_ZERO] & clb[CL_ZERO]);
  wire d_dbz   = ~d_inv & clb[CL_ZERO];
  wire div_regular = ~d_zero & ~d_sat & ~d_flush;

  // Multiply special results
  wire m_zero = cla[CL_ZERO] | clb[CL_ZERO] | cla[CL_DEN] | clb[CL_DEN];
  wire m_sat  = ~m_zero & (bad_a | bad_b);
  wire m_inv  = bad_a | bad_b;

  // Mantissa datapath
  wire        div_done;
  wire [56:0] q_div;
  wire        div_rem_nz;
  wire        div_start = state_reg == ST_EXEC && is_dv && div_regular;
  wire [105:0] prod = man_a * man_b;

  dpfc_div u_div (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (div_start),
    .man_n  (man_a),
    .man_d  (man_b),
    .done   (div_done),
    .quot   (q_div),
    .rem_nz (div_rem_nz)
  );

  // Normalise to 56 bits plus sticky
  wire [55:0] nrm = is_dv ? (q_div[56] ? q_div[56:1] : q_div[55:0])
                          : (prod[105] ? prod[105:50] : prod[104:49]);
  wire nrm_x = is_dv ? ((q_div[56] & q_div[0]) | div_rem_nz)
                     : (prod[105] ? (|prod[49:0]) : (|prod[48:0]));
  wire signed [13:0] exp_u = is_dv
         ? exp_a - exp_b + EXP_BIAS - (q_div[56] ? 14'sd0 : 14'sd1)
         : exp_a + exp_b - EXP_BIAS + (prod[105] ? 14'sd1 : 14'sd0);
  wire        ar_g  = nrm[2];
  wire        ar_s  = (|nrm[1:0]) | nrm_x;
  wire        ar_up = rnd_inc(rm, sgn_r, nrm[3], ar_g, ar_s);
  wire [53:0] man_r = {1'b0, nrm[55:3]} + {53'h0, ar_up};
  wire signed [13:0] exp_r = exp_u + (man_r[53] ? 14'sd1 : 14'sd0);
  wire [63:0] ar_rnd = {sgn_r, exp_r[10:0], man_r[53] ? man_r[52:1] : man_r[51:0]};
  wire [63:0] ar_trn = {sgn_r, exp_u[10:0], nrm[54:3]};

  // Arithmetic exception priority
  wire sp_zero = is_dv ? (d_zero | d_flush) : m_zero;
  wire sp_sat  = is_dv ? d_sat : m_sat;
  wire ar_reg  = ~sp_zero & ~sp_sat;
  wire ar_inv  = is_dv ? d_inv : m_inv;
  wire ar_dbz  = is_dv & d_dbz;
  wire ov_f    = ~ar_inv & ar_reg & (exp_r >= EXP_TOP);
  wire un_f    = ~ar_inv & ar_reg & ~ov_f & (exp_u <= 14'sd0);
  wire ar_hard = (ar_inv & en_inv) | (ar_dbz & en_dbz)
               | (ov_f & en_ovf) | (un_f & en_unf);
  wire ar_inx  = ~ar_hard & (ov_f | (ar_reg & ~un_f & (ar_g | ar_s)));
  wire ar_clr  = ar_inv | ar_dbz | ov_f | un_f;
  wire [63:0] ar_res = sp_zero ? {sgn_r, 63'h0} :
                       (sp_sat | ov_f) ? {sgn_r, MAX_MAG} :
                       un_f ? {sgn_r, 63'h0} :
                       (ar_inx & en_inx) ? ar_trn : ar_rnd;

  // Conversions
  wire [63:0] cv_rnd;
  wire [63:0] cv_trn;
  wire        cv_inv;
  wire        cv_inx;
  wire        cv_grd;
  wire        cv_stk;

  dpfc_cvt u_cvt (
    .src     (src_b_reg),
    .is_frac (op_reg == OP_CUF),
    .wide    (op_reg == OP_CUIDZ),
    .trunc   (op_reg == OP_CUIZ || op_reg == OP_CUIDZ),
    .rmode   (rm),
    .res_rnd (cv_rnd),
    .res_trn (cv_trn),
    .invalid (cv_inv),
    .inexact (cv_inx),
    .guard   (cv_grd),
    .sticky  (cv_stk)
  );

  // Merge of both datapaths
  wire        f_inv  = is_cv ? cv_inv : ar_inv;
  wire        f_dbz  = ~is_cv & ar_dbz;
  wire        f_ovf  = ~is_cv & ov_f;
  wire        f_unf  = ~is_cv & un_f;
  wire        f_hard = is_cv ? (cv_inv & en_inv) : ar_hard;
  wire        f_inx  = is_cv ? cv_inx : ar_inx;
  wire        f_rirq = f_inx & en_inx;
  wire        f_grd  = is_cv ? cv_grd : (~ar_clr & ar_reg & ar_g);
  wire        f_stk  = is_cv ? cv_stk : (~ar_clr & ar_reg & ar_s);
  wire        f_full = ~is_cv | (op_reg == OP_CUIDZ);
  wire [63:0] cv_pick = f_rirq ? cv_trn : cv_rnd;
  wire [63:0] f_data = ~is_cv ? ar_res :
                       f_full ? cv_pick : {32'h0, cv_pick[31:0]};

  // Sequencing
  wire finish = (state_reg == ST_EXEC && !div_start) || (state_reg == ST_DIVW && div_done);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (accept) state_next = ST_EXEC;
      ST_EXEC: state_next = div_start ? ST_DIVW : ST_IDLE;
      ST_DIVW: if (div_done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Register port decode
  wire        sel_st  = reg_addr == REG_STATUS;
  wire        sel_ct  = reg_addr == REG_CTRL;
  wire [6:0]  st_base = (reg_wr & sel_st) ? reg_wdata[6:0] : status_reg;
  wire [6:0]  st_hw   = {f_stk, f_grd, st_base[ST_INX] | f_inx, f_unf, f_ovf, f_dbz, f_inv};
  wire [31:0] rd_mux  = sel_st ? {25'h0, status_reg} :
                        sel_ct ? {25'h0, ctrl_reg} : 32'h0;
  assign status_next = finish ? st_hw : st_base;
  assign ctrl_next   = (reg_wr & sel_ct) ? reg_wdata[6:0] : ctrl_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      status_reg <= STATUS_RST;
      ctrl_reg   <= CTRL_RST;
      rdata_reg  <= 32'h0;
    end else begin
      state_reg  <= state_next;
      status_reg <= status_next;
      ctrl_reg   <= ctrl_next;
      rdata_reg  <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Operand capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_reg    <= OP_CUF;
      src_a_reg <= 64'h0;
      src_b_reg <= 64'h0;
      dst_reg   <= 5'h00;
      ia_reg    <= 5'h00;
      ib_reg    <= 5'h00;
    end else if (accept) begin
      op_reg    <= op_next;
      src_a_reg <= src_a_data;
      src_b_reg <= src_b_data;
      dst_reg   <= ins_dst;
      ia_reg    <= ins_a;
      ib_reg    <= ins_b;
    end
  end

  // Result stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      wb_en_reg     <= 1'b0;
      wb_full_reg   <= 1'b0;
      irq_data_reg  <= 1'b0;
      irq_round_reg <= 1'b0;
    end else begin
      busy_reg      <= state_next != ST_IDLE;
      done_reg      <= finish;
      wb_en_reg     <= finish & ~f_hard;
      wb_full_reg   <= finish & f_full;
      irq_data_reg  <= finish & f_hard;
      irq_round_reg <= finish & f_rirq;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wb_dst_reg   <= 5'h00;
      wb_src_a_reg <= 5'h00;
      wb_src_b_reg <= 5'h00;
      wb_data_reg  <= 64'h0;
    end else if (finish) begin
      wb_dst_reg   <= dst_reg;
      wb_src_a_reg <= ia_reg;
      wb_src_b_reg <= ib_reg;
      wb_data_reg  <= f_data;
    end
  end

  assign busy      = busy_reg;
  assign done      = done_reg;
  assign wb_en     = wb_en_reg;
  assign wb_full   = wb_full_reg;
  assign wb_dst    = wb_dst_reg;
  assign wb_src_a  = wb_src_a_reg;
  assign wb_src_b  = wb_src_b_reg;
  assign wb_data   = wb_data_reg;
  assign irq_data  = irq_data_reg;
  assign irq_round = irq_round_reg;
  assign reg_rdata = rdata_reg;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_NAN_ZERO:
    assert property (done_reg && wb_en_reg && is_cv && clb[CL_NAN] |-> wb_data_reg == 64'h0)
    else $error("NaN conversion result not zero");
  AST_LOW_WORD:
    assert property (done_reg && is_cv && op_reg != OP_CUIDZ
                     |-> !wb_full_reg && wb_data_reg[63:32] == 32'h0)
    else $error("32-bit conversion touched high word");
  AST_DW_FULL:
    assert property (done_reg && op_reg == OP_CUIDZ |-> wb_full_reg)
    else $error("doubleword conversion not full width");
  AST_CV_INV:
    assert property (done_reg && is_cv && status_reg[ST_INV] && $past(en_inv)
                     |-> !wb_en_reg && irq_data_reg && !status_reg[ST_GRD] && !status_reg[ST_STK])
    else $error("conversion invalid not handled");
  AST_DIV_ZERO:
    assert property (done_reg && wb_en_reg && is_dv && (clb[CL_NAN] || clb[CL_INF])
                     |-> wb_data_reg == {sgn_r, 63'h0})
    else $error("divide by NaN or infinity not zero");
  AST_MUL_ZERO:
    assert property (done_reg && wb_en_reg && is_ml && m_zero |-> wb_data_reg == {sgn_r, 63'h0})
    else $error("multiply by zero not zero");
  AST_MUL_SAT:
    assert property (done_reg && wb_en_reg && is_ml && !m_zero && m_inv
                     |-> wb_data_reg == {sgn_r, MAX_MAG})
    else $error("multiply special not saturated");
  AST_GS_CLR:
    assert property (done_reg && !is_cv && (|status_reg[ST_UNF:ST_INV])
                     |-> status_reg[ST_STK:ST_GRD] == 2'b00)
    else $error("guard bits not cleared");
  AST_LATENCY:
    assert property (accept && op_next != OP_DIV
                     |-> ##2 done_reg && wb_dst_reg == $past(ins_dst, 2))
    else $error("result not two cycles after issue");
  AST_DIV_LAT:
    assert property (accept && op_next == OP_DIV |-> ##[2:60] done_reg)
    else $error("divide did not complete in time");
endmodule : dpfc_core

// *** logic/dpfc_cvt.sv ***
`timescale 1ns/1ps
module dpfc_cvt
  import dpfc_pkg::*;
(
  input  wire logic [63:0] src,
  input  wire logic        is_frac,
  input  wire logic        wide,
  input  wire logic        trunc,
  input  wire logic [1:0]  rmode,
  output logic      [63:0] res_rnd,
  output logic      [63:0] res_trn,
  output logic             invalid,
  output logic             inexact,
  output logic             guard,
  output logic             sticky
);
  wire [3:0] cl = dp_class(src);
  wire       sgn = src[63];
  wire       num = ~(|cl);
  // Binary point position of the result
  wire signed [12:0] sh = $signed({2'b00, src[62:52]}) - 13'sd1023
                          + (is_frac ? 13'sd32 : 13'sd0);
  wire signed [12:0] lim = wide ? 13'sd64 : 13'sd32;
  wire big = sh >= lim;
  wire tiny = sh < -13'sd1;
  wire signed [12:0] rsh_w = 13'sd63 - sh;
  wire [6:0]   rsh = (big | tiny) ? 7'h00 : rsh_w[6:0];
  wire [127:0] win = {1'b1, src[51:0], 75'h0} >> rsh;
  wire [63:0]  ip = tiny ? 64'h0 : win[127:64];
  wire         g = ~tiny & win[63];
  wire         s = tiny | (|win[62:0]);
  wire         inc = ~trunc & rnd_inc(rmode, sgn, ip[0], g, s);
  wire [64:0]  ir = {1'b0, ip} + {64'h0, inc};
  wire [63:0]  umax = wide ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
  wire         rovf = wide ? ir[64] : (|ir[64:32]);
  // Negative values that round to non-zero cannot be unsigned
  wire         ovf = num & (big | (sgn ? (|ir) : rovf));
  wire         sat = (cl[CL_INF] | ovf) & ~sgn;

  assign invalid = cl[CL_NAN] | cl[CL_INF] | cl[CL_DEN] | ovf;
  assign res_rnd = sat ? umax : (num & ~sgn) ? ir[63:0] : 64'h0;
  assign res_trn = sat ? umax : (num & ~sgn) ? ip : 64'h0;
  assign inexact = num & ~ovf & (g | s);
  assign guard   = num & ~ovf & g;
  assign sticky  = num & ~ovf & s;
endmodule : dpfc_cvt

// *** logic/dpfc_div.sv ***
`timescale 1ns/1ps
module dpfc_div
  import dpfc_pkg::*;
#(
  parameter int STEPS = DIV_STEPS
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [52:0] man_n,
  input  wire logic [52:0] man_d,
  output logic             done,
  output logic [56:0]      quot,
  output logic             rem_nz
);
  if (STEPS != 57) begin : g_chk
    $error("dpfc_div: STEPS must be 57");
  end

  logic [53:0] rem_reg;
  logic [52:0] den_reg;
  logic [56:0] quot_reg;
  logic [5:0]  cnt_reg;
  logic        run_reg;
  logic        done_reg;
  wire  [54:0] diff = {1'b0, rem_reg} - {2'b00, den_reg};
  wire         take = ~diff[54];

  // Restoring division, one quotient bit per cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rem_reg  <= 54'h0;
      den_reg  <= 53'h0;
      quot_reg <= 57'h0;
      cnt_reg  <= 6'h00;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      rem_reg  <= {1'b0, man_n};
      den_reg  <= man_d;
      cnt_reg  <= 6'(STEPS - 1);
      run_reg  <= 1'b1;
      done_reg <= 1'b0;
    end else if (run_reg) begin
      quot_reg <= {quot_reg[55:0], take};
      rem_reg  <= take ? {diff[52:0], 1'b0} : {rem_reg[52:0], 1'b0};
      cnt_reg  <= cnt_reg - 6'h01;
      run_reg  <= cnt_reg != 6'h00;
      done_reg <= cnt_reg == 6'h00;
    end else begin
      done_reg <= 1'b0;
    end
  end

  assign done   = done_reg;
  assign quot   = quot_reg;
  assign rem_nz = |rem_reg;
endmodule : dpfc_div

// *** logic/dpfc_pkg.sv ***
package dpfc_pkg;
  // Instruction encoding
  localparam logic [5:0]  PRIMARY_OP = 6'h04;
  localparam logic [10:0] XO_CUF     = 11'h2F6;
  localparam logic [10:0] XO_CUI     = 11'h2F4;
  localparam logic [10:0] XO_CUIZ    = 11'h2F8;
  localparam logic [10:0] XO_CUIDZ   = 11'h2EA;
  localparam logic [10:0] XO_DIV     = 11'h2E9;
  localparam logic [10:0] XO_MUL     = 11'h2E8;
  // Register map
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_CTRL   = 8'h04;
  localparam logic [6:0]  STATUS_RST = 7'h00;
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam int ST_INV = 0;
  localparam int ST_DBZ = 1;
  localparam int ST_OVF = 2;
  localparam int ST_UNF = 3;
  localparam int ST_INX = 4;
  localparam int ST_GRD = 5;
  localparam int ST_STK = 6;
  localparam int EN_INV = 0;
  localparam int EN_DBZ = 1;
  localparam int EN_OVF = 2;
  localparam int EN_UNF = 3;
  localparam int EN_INX = 4;
  localparam int CT_RM  = 5;
  // Operand classes
  localparam int CL_ZERO = 0;
  localparam int CL_DEN  = 1;
  localparam int CL_INF  = 2;
  localparam int CL_NAN  = 3;
  // Arithmetic constants
  localparam int DIV_STEPS = 57;
  localparam logic [62:0] MAX_MAG = 63'h7FEF_FFFF_FFFF_FFFF;
  localparam logic signed [13:0] EXP_BIAS = 14'sh03FF;
  localparam logic signed [13:0] EXP_TOP  = 14'sh07FF;

  typedef enum logic [1:0] {RM_NEAR = 2'h0, RM_ZERO = 2'h1,
                            RM_PINF = 2'h2, RM_NINF = 2'h3} dpfc_rm_t;
  typedef enum logic [2:0] {OP_CUF = 3'h0, OP_CUI = 3'h1, OP_CUIZ = 3'h2,
                            OP_CUIDZ = 3'h3, OP_DIV = 3'h4, OP_MUL = 3'h5} dpfc_op_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01,
                            ST_DIVW = 2'b10} dpfc_state_t;

  // Class bits {nan, inf, denormal, zero}
  function automatic logic [3:0] dp_class(input logic [63:0] v);
    logic ex_max;
    logic ex_min;
    logic fr_nz;
    ex_max = v[62:52] == 11'h7FF;
    ex_min = v[62:52] == 11'h000;
    fr_nz = |v[51:0];
    dp_class = {ex_max & fr_nz, ex_max & ~fr_nz, ex_min & fr_nz, ex_min & ~fr_nz};
  endfunction : dp_class

  // Round-up decision for magnitude rounding
  function automatic logic rnd_inc(input logic [1:0] rm, input logic sgn,
                                   input logic lsb, input logic g, input logic s);
    case (rm)
      RM_NEAR: rnd_inc = g & (s | lsb);
      RM_PINF: rnd_inc = ~sgn & (g | s);
      RM_NINF: rnd_inc = sgn & (g | s);
      default: rnd_inc = 1'b0;
    endcase
  endfunction : rnd_inc
endpackage : dpfc_pkg
